// [hw/interrupt_entry_sequencer.sv]
// Chosen here: the register offsets and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none

module interrupt_entry_sequencer (
	// Clock, reset, enable
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	input  wire logic                   clk_en,
	// AHB-Lite slave
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output logic                        hreadyout,
	output logic                        hresp,
	output logic [31:0]                 hrdata,
	// Arbiter side
	input  wire logic                   req_valid,
	input  wire irq_entry_pkg::req_s    req,
	output logic                        flag_clear,
	// Pipeline side
	input  wire irq_entry_pkg::hazard_s haz,
	input  wire logic [3:0]             ext_pending,
	input  wire logic                   muldiv_busy,
	input  wire logic [15:0]            muldiv_addr,
	input  wire logic [15:0]            next_ip,
	input  wire logic                   instr_done,
	input  wire logic                   return_from_interrupt_instr_exec,
	input  wire logic                   switch_context_instr_exec,
	input  wire logic [15:0]            switch_context_instr_operand,
	output logic                        inject_trap,
	output logic                        inject_xfer,
	output logic                        stall_next,
	output logic                        vector_fetch,
	output logic                        xfer_start,
	output logic [15:0]                 ip_out,
	output logic [15:0]                 csp_out,
	output logic [15:0]                 cp_out,
	output logic [15:0]                 psw_out,
	output logic                        seq_busy
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	irq_entry_pkg::seq_state_e state_r;
	irq_entry_pkg::seq_state_e state_nxt;
	irq_entry_pkg::req_s       req_r;

	logic [15:0] ctrl_r;
	logic [15:0] psw_r;
	logic [15:0] ip_r;
	logic [15:0] csp_r;
	logic [15:0] cp_r;
	logic [15:0] sp_r;
	logic [15:0] ret_ip_r;
	logic [15:0] stack_mem [irq_entry_pkg::STACK_WORDS];
	logic [4:0]  cnt_r;
	logic [4:0]  target_r;
	logic [1:0]  stall_cnt_r;
	logic [1:0]  guard_r;
	logic        muldiv_in_progress_flag_r;

	logic        segdis;
	logic        push_en;
	logic [15:0] push_data;
	logic        pop_en;
	logic [15:0] pop_data;
	logic [15:0] sp_dec;
	logic        accept;
	logic [4:0]  extra;

	// Bus side
	logic        wr_pend_r;
	logic [7:0]  wr_addr_r;
	logic        bus_acc;
	logic        wr_ctrl;
	logic        wr_psw;
	logic        wr_ip;
	logic        wr_csp;
	logic        wr_cp;
	logic        wr_sp;
	logic [15:0] wdat;
	logic [31:0] rd_mux;

	assign segdis   = ctrl_r[irq_entry_pkg::CTRL_SEGDIS_BIT];
	assign sp_dec   = sp_r - irq_entry_pkg::SP_STEP;
	assign pop_data = stack_mem[sp_r[4:1]];

	// ----------------------------------------------------------------
	// Request acceptance and response targets
	// ----------------------------------------------------------------
	// guard after return
	assign accept = req_valid && (guard_r == 2'h0);

	always_comb begin
		extra = {3'h0, haz.hold_cnt};
		if (haz.first_state) begin
			extra = extra + irq_entry_pkg::FIRST_STATE_EXTRA;
		end
		if (haz.reads_psw && haz.prev_sets_flags) begin
			extra = extra + irq_entry_pkg::FLAG_READ_EXTRA;
		end
		if (!req.chan && haz.writes_psw_sp) begin
			extra = extra + irq_entry_pkg::PSW_SP_EXTRA;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			irq_entry_pkg::ST_IDLE: begin
				if (return_from_interrupt_instr_exec) begin
					state_nxt = irq_entry_pkg::ST_POP_IP;
				end else if (!switch_context_instr_exec && accept) begin
					state_nxt = irq_entry_pkg::ST_PRIO;
				end
			end
			irq_entry_pkg::ST_PRIO: begin
				// repeat round on control read
				// Only the first round repeats, so a read that stays up cannot hold off entry
				if (!(req_r.chan && haz.reads_chan_ctrl && cnt_r == 5'h01)) begin
					state_nxt = irq_entry_pkg::ST_INJECT;
				end
			end
			irq_entry_pkg::ST_INJECT: begin
				if (req_r.chan) begin
					state_nxt = irq_entry_pkg::ST_XFER;
				end else begin
					state_nxt = irq_entry_pkg::ST_PUSH_PSW;
				end
			end
			irq_entry_pkg::ST_PUSH_PSW: begin
				if (segdis) begin
					state_nxt = irq_entry_pkg::ST_PUSH_IP;
				end else begin
					state_nxt = irq_entry_pkg::ST_PUSH_CSP;
				end
			end
			irq_entry_pkg::ST_PUSH_CSP: begin
				state_nxt = irq_entry_pkg::ST_PUSH_IP;
			end
			irq_entry_pkg::ST_PUSH_IP: begin
				state_nxt = irq_entry_pkg::ST_WAIT;
			end
			irq_entry_pkg::ST_WAIT: begin
				if (cnt_r >= target_r && ext_pending == 4'h0) begin
					state_nxt = irq_entry_pkg::ST_IDLE;
				end
			end
			irq_entry_pkg::ST_XFER: begin
				if (cnt_r >= target_r && ext_pending == 4'h0) begin
					state_nxt = irq_entry_pkg::ST_RESUME;
				end
			end
			irq_entry_pkg::ST_RESUME: begin
				if (stall_cnt_r == 2'h0 && ext_pending == 4'h0) begin
					state_nxt = irq_entry_pkg::ST_IDLE;
				end
			end
			irq_entry_pkg::ST_POP_IP: begin
				if (segdis) begin
					state_nxt = irq_entry_pkg::ST_POP_PSW;
				end else begin
					state_nxt = irq_entry_pkg::ST_POP_CSP;
				end
			end
			irq_entry_pkg::ST_POP_CSP: begin
				state_nxt = irq_entry_pkg::ST_POP_PSW;
			end
			irq_entry_pkg::ST_POP_PSW: begin
				state_nxt = irq_entry_pkg::ST_IDLE;
			end
			default: begin
				state_nxt = irq_entry_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= irq_entry_pkg::ST_IDLE;
		end else if (clk_en) begin
			state_r <= state_nxt;
		end
	end

	// Captured request and response target
	// interrupt minimum five states
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_r    <= '0;
			target_r <= 5'h00;
		end else if (clk_en) begin
			if (state_r == irq_entry_pkg::ST_IDLE && state_nxt == irq_entry_pkg::ST_PRIO) begin
				req_r <= req;
				if (req.chan) begin
					target_r <= irq_entry_pkg::CHAN_MIN_STATES + extra;
				end else begin
					target_r <= irq_entry_pkg::INT_MIN_STATES + extra;
				end
			end else if (state_r == irq_entry_pkg::ST_PRIO && state_nxt == irq_entry_pkg::ST_PRIO) begin
				target_r <= target_r + irq_entry_pkg::CHAN_REPEAT_EXTRA;
			end
		end
	end

	// States elapsed since the request was taken; saturates
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= 5'h00;
		end else if (clk_en) begin
			if (state_nxt == irq_entry_pkg::ST_PRIO && state_r == irq_entry_pkg::ST_IDLE) begin
				cnt_r <= 5'h01;
			end else if (cnt_r != 5'h1F) begin
				cnt_r <= cnt_r + 5'h01;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag_clear  <= 1'b0;
			inject_trap <= 1'b0;
			inject_xfer <= 1'b0;
		end else if (clk_en) begin
			flag_clear  <= state_nxt == irq_entry_pkg::ST_INJECT;
			inject_trap <= state_nxt == irq_entry_pkg::ST_INJECT && !req_r.chan;
			inject_xfer <= state_nxt == irq_entry_pkg::ST_INJECT && req_r.chan;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vector_fetch <= 1'b0;
			xfer_start   <= 1'b0;
		end else if (clk_en) begin
			vector_fetch <= state_r == irq_entry_pkg::ST_WAIT && state_nxt == irq_entry_pkg::ST_IDLE;
			xfer_start   <= state_r == irq_entry_pkg::ST_XFER && state_nxt == irq_entry_pkg::ST_RESUME;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stall_cnt_r <= 2'h0;
			stall_next  <= 1'b0;
		end else if (clk_en) begin
			if (state_nxt == irq_entry_pkg::ST_RESUME && state_r == irq_entry_pkg::ST_XFER) begin
				stall_cnt_r <= irq_entry_pkg::CHAN_STALL_STATES - 2'h1;
			end else if (stall_cnt_r != 2'h0) begin
				stall_cnt_r <= stall_cnt_r - 2'h1;
			end
			stall_next <= req_r.chan && (state_nxt == irq_entry_pkg::ST_INJECT ||
				state_nxt == irq_entry_pkg::ST_XFER || state_nxt == irq_entry_pkg::ST_RESUME);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			guard_r <= 2'h0;
		end else if (clk_en) begin
			if (state_r == irq_entry_pkg::ST_POP_PSW) begin
				guard_r <= irq_entry_pkg::RETURN_FROM_INTERRUPT_INSTR_GUARD_CYCLES;
			end else if (instr_done && guard_r != 2'h0) begin
				guard_r <= guard_r - 2'h1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ret_ip_r <= 16'h0000;
			muldiv_in_progress_flag_r  <= 1'b0;
		end else if (clk_en && state_r == irq_entry_pkg::ST_INJECT && !req_r.chan) begin
			muldiv_in_progress_flag_r  <= muldiv_busy;
			ret_ip_r <= muldiv_busy ? muldiv_addr : next_ip;
		end
	end

	// ----------------------------------------------------------------
	// System stack
	// ----------------------------------------------------------------
	always_comb begin
		push_en   = 1'b0;
		push_data = 16'h0000;
		pop_en    = 1'b0;
		case (state_r)
			irq_entry_pkg::ST_PUSH_PSW: begin
				push_en   = 1'b1;
				push_data = psw_r;
				push_data[irq_entry_pkg::PSW_MULDIV_IN_PROGRESS_FLAG_BIT] = muldiv_in_progress_flag_r;
			end
			irq_entry_pkg::ST_PUSH_CSP: begin
				push_en   = 1'b1;
				push_data = csp_r;
			end
			irq_entry_pkg::ST_PUSH_IP: begin
				push_en   = 1'b1;
				push_data = ret_ip_r;
			end
			irq_entry_pkg::ST_POP_IP,
			irq_entry_pkg::ST_POP_CSP,
			irq_entry_pkg::ST_POP_PSW: begin
				pop_en = 1'b1;
			end
			irq_entry_pkg::ST_IDLE: begin
				push_en   = switch_context_instr_exec && !return_from_interrupt_instr_exec;
				push_data = cp_r;
			end
			default: begin
				push_en = 1'b0;
			end
		endcase
	end

	always_ff @(posedge hclk) begin
		if (clk_en && push_en) begin
			stack_mem[sp_dec[4:1]] <= push_data;
		end
	end

	// ----------------------------------------------------------------
	// Architectural registers; hardware updates win over bus writes
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sp_r <= irq_entry_pkg::SP_RST;
		end else if (clk_en) begin
			if (push_en) begin
				sp_r <= sp_dec;
			end else if (pop_en) begin
				sp_r <= sp_r + irq_entry_pkg::SP_STEP;
			end else if (wr_sp) begin
				sp_r <= wdat;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			psw_r <= irq_entry_pkg::PSW_RST;
		end else if (clk_en) begin
			if (state_r == irq_entry_pkg::ST_PUSH_IP) begin
				psw_r[irq_entry_pkg::PSW_CPU_PRIORITY_FIELD_LSB +: 4] <= req_r.level;
				psw_r[irq_entry_pkg::PSW_MULDIV_IN_PROGRESS_FLAG_BIT]     <= muldiv_in_progress_flag_r;
			end else if (state_r == irq_entry_pkg::ST_POP_PSW) begin
				psw_r <= pop_data;
			end else if (wr_psw) begin
				psw_r <= wdat;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ip_r <= irq_entry_pkg::IP_RST;
		end else if (clk_en) begin
			if (state_r == irq_entry_pkg::ST_PUSH_IP) begin
				ip_r <= req_r.vector;
			end else if (state_r == irq_entry_pkg::ST_POP_IP) begin
				ip_r <= pop_data;
			end else if (wr_ip) begin
				ip_r <= wdat;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			csp_r <= irq_entry_pkg::CSP_RST;
		end else if (clk_en) begin
			if (state_r == irq_entry_pkg::ST_PUSH_IP && !segdis) begin
				csp_r <= 16'h0000;
			end else if (state_r == irq_entry_pkg::ST_POP_CSP) begin
				csp_r <= pop_data;
			end else if (wr_csp) begin
				csp_r <= wdat;
			end
		end
	end

	// Entry leaves the context pointer alone; only the switch or a bus write to ADDR_CP moves it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cp_r <= irq_entry_pkg::CP_RST;
		end else if (clk_en) begin
			if (state_r == irq_entry_pkg::ST_IDLE && switch_context_instr_exec && !return_from_interrupt_instr_exec) begin
				cp_r <= switch_context_instr_operand;
			end else if (wr_cp) begin
				cp_r <= wdat;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r <= irq_entry_pkg::CTRL_RST;
		end else if (clk_en && wr_ctrl) begin
			ctrl_r <= wdat;
		end
	end

	// ----------------------------------------------------------------
	// AHB-Lite slave, zero wait states
	// ----------------------------------------------------------------
	assign bus_acc = hsel && htrans[1] && hready && (hsize == 3'h2);
	assign wdat    = hwdata[15:0];
	assign wr_ctrl = wr_pend_r && wr_addr_r == irq_entry_pkg::ADDR_CTRL;
	assign wr_psw  = wr_pend_r && wr_addr_r == irq_entry_pkg::ADDR_PSW;
	assign wr_ip   = wr_pend_r && wr_addr_r == irq_entry_pkg::ADDR_IP;
	assign wr_csp  = wr_pend_r && wr_addr_r == irq_entry_pkg::ADDR_CSP;
	assign wr_cp   = wr_pend_r && wr_addr_r == irq_entry_pkg::ADDR_CP;
	assign wr_sp   = wr_pend_r && wr_addr_r == irq_entry_pkg::ADDR_SP;

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (haddr[7:0])
			irq_entry_pkg::ADDR_CTRL:   rd_mux = {16'h0000, ctrl_r};
			irq_entry_pkg::ADDR_PSW:    rd_mux = {16'h0000, psw_r};
			irq_entry_pkg::ADDR_IP:     rd_mux = {16'h0000, ip_r};
			irq_entry_pkg::ADDR_CSP:    rd_mux = {16'h0000, csp_r};
			irq_entry_pkg::ADDR_CP:     rd_mux = {16'h0000, cp_r};
			irq_entry_pkg::ADDR_SP:     rd_mux = {16'h0000, sp_r};
			irq_entry_pkg::ADDR_STATUS: rd_mux = {24'h00_0000, guard_r, 2'h0, state_r};
			default:                    rd_mux = 32'h0000_0000;
		endcase
		if (haddr[31:8] != 24'h00_0000) begin
			rd_mux = 32'h0000_0000;
		end
	end

	// Read data is prepared in the address phase so it stands from a flop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			hrdata    <= 32'h0000_0000;
		end else if (clk_en) begin
			wr_pend_r <= bus_acc && hwrite && haddr[31:8] == 24'h00_0000;
			wr_addr_r <= haddr[7:0];
			if (bus_acc && !hwrite) begin
				hrdata <= rd_mux;
			end
		end
	end

	// Never stalls and never errors
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Mirrored state for the pipeline
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ip_out   <= irq_entry_pkg::IP_RST;
			csp_out  <= irq_entry_pkg::CSP_RST;
			cp_out   <= irq_entry_pkg::CP_RST;
			psw_out  <= irq_entry_pkg::PSW_RST;
			seq_busy <= 1'b0;
		end else if (clk_en) begin
			ip_out   <= ip_r;
			csp_out  <= csp_r;
			cp_out   <= cp_r;
			psw_out  <= psw_r;
			seq_busy <= state_nxt != irq_entry_pkg::ST_IDLE;
		end
	end

endmodule : interrupt_entry_sequencer

`default_nettype wire

// [hw/irq_entry_pkg.sv]
package irq_entry_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses, one word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_PSW    = 8'h04;
	localparam logic [7:0] ADDR_IP     = 8'h08;
	localparam logic [7:0] ADDR_CSP    = 8'h0C;
	localparam logic [7:0] ADDR_CP     = 8'h10;
	localparam logic [7:0] ADDR_SP     = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int          CTRL_SEGDIS_BIT = 0;
	localparam int          PSW_CPU_PRIORITY_FIELD_LSB    = 12;
	localparam int          PSW_MULDIV_IN_PROGRESS_FLAG_BIT   = 6;
	localparam logic [15:0] CTRL_RST        = 16'h0001;
	localparam logic [15:0] PSW_RST         = 16'h0000;
	localparam logic [15:0] IP_RST          = 16'h0000;
	localparam logic [15:0] CSP_RST         = 16'h0000;
	localparam logic [15:0] CP_RST          = 16'h0000;
	localparam logic [15:0] SP_RST          = 16'h0020;
	localparam logic [15:0] SP_STEP         = 16'h0002;
	localparam int          STACK_WORDS     = 16;

	// ----------------------------------------------------------------
	// Response timing, in state times (one state is one hclk with clk_en high); the return guard counts completed instructions
	// ----------------------------------------------------------------
	localparam logic [4:0] INT_MIN_STATES    = 5'h05;
	localparam logic [4:0] CHAN_MIN_STATES   = 5'h03;
	localparam logic [4:0] FIRST_STATE_EXTRA = 5'h01;
	localparam logic [4:0] PSW_SP_EXTRA      = 5'h01;
	localparam logic [4:0] FLAG_READ_EXTRA   = 5'h02;
	localparam logic [4:0] CHAN_REPEAT_EXTRA = 5'h01;
	localparam logic [1:0] CHAN_STALL_STATES = 2'h2;
	localparam logic [1:0] RETURN_FROM_INTERRUPT_INSTR_GUARD_CYCLES = 2'h2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE     = 4'h0,
		ST_PRIO     = 4'h1,
		ST_INJECT   = 4'h3,
		ST_PUSH_PSW = 4'h2,
		ST_PUSH_CSP = 4'h6,
		ST_PUSH_IP  = 4'h7,
		ST_WAIT     = 4'h5,
		ST_XFER     = 4'hC,
		ST_RESUME   = 4'hD,
		ST_POP_IP   = 4'hF,
		ST_POP_CSP  = 4'hE,
		ST_POP_PSW  = 4'hA
	} seq_state_e;

	typedef struct packed {
		logic        chan;
		logic [3:0]  level;
		logic [15:0] vector;
	} req_s;

	typedef struct packed {
		logic [1:0] hold_cnt;
		logic       writes_psw_sp;
		logic       reads_psw;
		logic       prev_sets_flags;
		logic       reads_chan_ctrl;
		logic       first_state;
	} hazard_s;

endpackage : irq_entry_pkg

// [testbench/irq_entry_sva.sv]
`timescale 1ns/10ps
`default_nettype none

module irq_entry_sva (
	// Clock and reset
	input wire logic       hclk,
	input wire logic       hresetn,
	// Watched pipeline side
	input wire logic [3:0] ext_pending,
	input wire logic       flag_clear,
	input wire logic       inject_trap,
	input wire logic       inject_xfer,
	input wire logic       stall_next,
	input wire logic       vector_fetch,
	input wire logic       xfer_start
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// ----
	// Entry steps
	// ----
	sequence trap_quiet_s;
		!vector_fetch [*3];
	endsequence
	sequence xfer_quiet_s;
		!xfer_start;
	endsequence

	trap_clears_a: assert property (inject_trap |-> flag_clear)
		else $error("trap injected without flag clear");
	xfer_clears_a: assert property (inject_xfer |-> flag_clear && !inject_trap)
		else $error("transfer injected badly");
	trap_fetch_a: assert property (inject_trap |=> trap_quiet_s ##[1:300] vector_fetch)
		else $error("vector fetch early or missing");
	xfer_go_a: assert property (inject_xfer |=> xfer_quiet_s ##[1:300] xfer_start)
		else $error("transfer start early or missing");
	bus_drain_a: assert property (vector_fetch |-> $past(ext_pending) == 4'h0)
		else $error("vector fetch with bus busy");
	xfer_stall_a: assert property (xfer_start |-> stall_next [*2])
		else $error("next instruction not held two states");
	clear_pulse_a: assert property (flag_clear |=> !flag_clear)
		else $error("flag clear not one pulse");
	fetch_once_a: assert property (vector_fetch |=> !vector_fetch && !xfer_start)
		else $error("vector fetch repeated");
endmodule : irq_entry_sva

bind interrupt_entry_sequencer irq_entry_sva u_irq_entry_sva (
	.hclk         (hclk),
	.hresetn      (hresetn),
	.ext_pending  (ext_pending),
	.flag_clear   (flag_clear),
	.inject_trap  (inject_trap),
	.inject_xfer  (inject_xfer),
	.stall_next   (stall_next),
	.vector_fetch (vector_fetch),
	.xfer_start   (xfer_start)
);

`default_nettype wire

// [testbench/pipe_model.sv]
`timescale 1ns/10ps
`default_nettype none

module pipe_model (
	// Clock and reset
	input wire logic                hclk,
	input wire logic                hresetn,
	// Bench control
	input wire logic                go,
	input wire irq_entry_pkg::req_s rq,
	input wire logic [3:0]          pend,
	// Sequencer side
	input wire logic                flag_clear,
	output logic                    req_valid,
	output irq_entry_pkg::req_s     req,
	output logic [3:0]              ext_pending,
	output logic                    instr_done
);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_valid <= 1'b0;
			req       <= '0;
		end else if (go) begin
			req_valid <= 1'b1;
			req       <= rq;
		end else if (flag_clear) begin
			req_valid <= 1'b0;
			req       <= ~req;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_pending <= 4'h0;
		end else if (go) begin
			ext_pending <= pend;
		end else if (ext_pending != 4'h0) begin
			ext_pending <= ext_pending - 4'h1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			instr_done <= 1'b0;
		end else begin
			instr_done <= ~instr_done;
		end
	end
endmodule : pipe_model

`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/10ps
`default_nettype none

module testbench;
	logic                    hclk, hresetn, hsel, hwrite, hreadyout, hresp, go, clk_en;
	logic [31:0]             haddr, hwdata, hrdata;
	logic [1:0]              htrans;
	logic [2:0]              hsize;
	logic [3:0]              pend, ext_pending;
	irq_entry_pkg::req_s     rq, req;
	irq_entry_pkg::hazard_s  haz;
	logic                    req_valid, flag_clear, instr_done, return_from_interrupt_instr_exec, switch_context_instr_exec, muldiv_busy;
	logic [15:0]             muldiv_addr, next_ip, switch_context_instr_operand, ip_out, csp_out, cp_out, psw_out;
	logic                    inject_trap, inject_xfer, stall_next, vector_fetch, xfer_start, seq_busy;
	int                      err_total, checks_done, cyc;

	interrupt_entry_sequencer u_interrupt_entry_sequencer (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .req_valid(req_valid),
		.req(req), .flag_clear(flag_clear), .haz(haz), .ext_pending(ext_pending), .muldiv_busy(muldiv_busy),
		.muldiv_addr(muldiv_addr), .next_ip(next_ip), .instr_done(instr_done), .return_from_interrupt_instr_exec(return_from_interrupt_instr_exec),
		.switch_context_instr_exec(switch_context_instr_exec), .switch_context_instr_operand(switch_context_instr_operand), .inject_trap(inject_trap),
		.inject_xfer(inject_xfer), .stall_next(stall_next), .vector_fetch(vector_fetch),
		.xfer_start(xfer_start), .ip_out(ip_out), .csp_out(csp_out), .cp_out(cp_out), .psw_out(psw_out),
		.seq_busy(seq_busy));

	pipe_model u_pipe_model (.hclk(hclk), .hresetn(hresetn), .go(go), .rq(rq), .pend(pend),
		.flag_clear(flag_clear), .req_valid(req_valid), .req(req), .ext_pending(ext_pending),
		.instr_done(instr_done));

	// ----
	// Shared tasks
	// ----
	task automatic tally_and_finish();
		if (err_total == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= 32'(a);
		hwrite <= w;
		hsize  <= 3'b010;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= 32'(d);
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata[15:0];
	endtask : bus

	task automatic idle_wait();
		@(negedge hclk);
		while (seq_busy !== 1'b0 && cyc < 39000) @(negedge hclk);
	endtask : idle_wait

	// Unsegmented or channel with a quiet bus must hit the minimum exactly
	task automatic service(input logic ch, input logic [3:0] pd);
		logic [15:0] q, cs;
		logic        sd;
		int          n, t;
		sd = 1'($urandom);
		cs = 16'($urandom);
		bus(1'b1, irq_entry_pkg::ADDR_CTRL, {15'h0, sd}, q);
		bus(1'b1, irq_entry_pkg::ADDR_PSW, 16'h0000, q);
		bus(1'b1, irq_entry_pkg::ADDR_CSP, cs, q);
		@(posedge hclk);
		haz         <= irq_entry_pkg::hazard_s'(7'($urandom));
		rq          <= {ch, 4'($urandom_range(15, 1)), 16'($urandom)};
		muldiv_busy <= 1'($urandom);
		muldiv_addr <= 16'($urandom);
		next_ip     <= 16'($urandom);
		pend        <= pd;
		go          <= 1'b1;
		@(posedge hclk);
		go <= 1'b0;
		n = 0;
		@(negedge hclk);
		while (!(ch ? xfer_start : vector_fetch) && n < 300) begin
			@(negedge hclk);
			n++;
		end
		t = (ch ? 4 : 6) + haz.hold_cnt + haz.first_state + 2 * (haz.reads_psw & haz.prev_sets_flags);
		t = t + (!ch & haz.writes_psw_sp) + (ch & haz.reads_chan_ctrl);
		chk("latency", 16'(t), 16'((pd == 0 && (ch || sd) || n < t) ? n : t));
		idle_wait();
		chk("cp_kept", 16'h5A3C, cp_out);
		chk("okay", 16'h0000, 16'(hresp));
		bus(1'b0, irq_entry_pkg::ADDR_SP, 16'h0000, q);
		chk("sp_in", ch ? 16'h0020 : (sd ? 16'h001C : 16'h001A), q);
		if (!ch) begin
			chk("ip_out", rq.vector, ip_out);
			chk("psw_out", {rq.level, 5'h00, muldiv_busy, 6'h00}, psw_out);
			chk("csp_out", sd ? cs : 16'h0000, csp_out);
			bus(1'b0, irq_entry_pkg::ADDR_PSW, 16'h0000, q);
			chk("psw_in", {rq.level, 5'h00, muldiv_busy, 6'h00}, q);
			bus(1'b0, irq_entry_pkg::ADDR_IP, 16'h0000, q);
			chk("ip_in", rq.vector, q);
			bus(1'b0, irq_entry_pkg::ADDR_CSP, 16'h0000, q);
			chk("csp_in", sd ? cs : 16'h0000, q);
			@(posedge hclk);
			return_from_interrupt_instr_exec <= 1'b1;
			@(posedge hclk);
			return_from_interrupt_instr_exec <= 1'b0;
			idle_wait();
			bus(1'b0, irq_entry_pkg::ADDR_IP, 16'h0000, q);
			chk("ip_ret", muldiv_busy ? muldiv_addr : next_ip, q);
			bus(1'b0, irq_entry_pkg::ADDR_CSP, 16'h0000, q);
			chk("csp_ret", cs, q);
			bus(1'b0, irq_entry_pkg::ADDR_PSW, 16'h0000, q);
			chk("lvl_ret", 16'h0000, {12'h000, q[15:12]});
			bus(1'b0, irq_entry_pkg::ADDR_SP, 16'h0000, q);
			chk("sp_ret", 16'h0020, q);
		end
		repeat (8) @(posedge hclk);
	endtask : service

	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end

	always @(posedge hclk) begin
		cyc++;
		if (cyc == 40000) begin
			err_total++;
			tally_and_finish();
		end
	end

	initial begin
		logic [15:0] q;
		{hresetn, hsel, hwrite, go, return_from_interrupt_instr_exec, switch_context_instr_exec, muldiv_busy} = '0;
		{haddr, hwdata, htrans, hsize, pend, rq, haz, muldiv_addr, next_ip, switch_context_instr_operand} = '0;
		{err_total, checks_done, cyc} = '0;
		clk_en = 1'b1;
		void'($urandom(32'h59cbd8ad));
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, irq_entry_pkg::ADDR_CTRL, 16'h0000, q);
		chk("ctrl_rst", 16'h0001, q);
		bus(1'b0, irq_entry_pkg::ADDR_SP, 16'h0000, q);
		chk("sp_rst", 16'h0020, q);
		bus(1'b0, 8'h1C, 16'h0000, q);
		chk("unmapped", 16'h0000, q);
		// no register use follows the switch
		@(posedge hclk);
		switch_context_instr_exec    <= 1'b1;
		switch_context_instr_operand <= 16'h5A3C;
		@(posedge hclk);
		switch_context_instr_exec <= 1'b0;
		idle_wait();
		bus(1'b0, irq_entry_pkg::ADDR_CP, 16'h0000, q);
		chk("cp_new", 16'h5A3C, q);
		bus(1'b0, irq_entry_pkg::ADDR_SP, 16'h0000, q);
		chk("sp_switch_context_instr", 16'h001E, q);
		// A write while the enable is low must not land
		clk_en <= 1'b0;
		bus(1'b1, irq_entry_pkg::ADDR_CP, 16'h1234, q);
		@(posedge hclk);
		clk_en <= 1'b1;
		bus(1'b0, irq_entry_pkg::ADDR_CP, 16'h0000, q);
		chk("cp_frozen", 16'h5A3C, q);
		bus(1'b1, irq_entry_pkg::ADDR_SP, 16'h0020, q);
		for (int i = 0; i < 14; i++) service(1'(i % 2), (i > 9) ? 4'(i - 6) : 4'h0);
		tally_and_finish();
	end
endmodule : testbench

`default_nettype wire
